// ===== hw/dpc_pkg.sv
package dpc_pkg;

   localparam int NUM_REGS = 24;
   localparam int ADDR_W = 5;

   // byte offsets of the global registers
   localparam logic [4:0] ADDR_MODE = 5'h14;
   localparam logic [4:0] ADDR_CLK = 5'h15;
   localparam logic [4:0] ADDR_XTAL = 5'h16;
   localparam logic [4:0] ADDR_STATUS = 5'h17;

   // writable bit masks; reserved and fixed bits stay zero
   localparam logic [7:0] MASK_MODE = 8'hFC;
   localparam logic [7:0] MASK_CLK = 8'hEF;
   localparam logic [7:0] MASK_XTAL = 8'h08;
   localparam logic [7:0] MASK_CFG = 8'hFF;

   // fixed pattern seen when reading the crystal register
   localparam logic [7:0] XTAL_FIXED = 8'hA0;

   // reset values
   localparam logic [7:0] RST_MODE = 8'h0C;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_PINS = 4'h3;

   // field positions in the global registers
   localparam int POS_MODE = 6;
   localparam int POS_CONFIG = 5;
   localparam int POS_SRC = 4;
   localparam int POS_OE1 = 3;
   localparam int POS_OE0 = 2;
   localparam int POS_CLKSEL = 7;
   localparam int POS_POLICY = 5;
   localparam int POS_RATE = 2;
   localparam int POS_WIN = 0;
   localparam int POS_DBL = 3;

   // pin vector positions
   localparam int PIN_OE0 = 0;
   localparam int PIN_OE1 = 1;
   localparam int PIN_CFG = 2;
   localparam int PIN_CLK = 3;

   // rate and window base figures
   localparam logic [4:0] RATE_BASE_DIV = 5'h10;
   localparam logic [4:0] WIN_BASE_US = 5'h02;

   typedef enum logic [1:0] {
      DPC_LOW_BW,
      DPC_SYNTH,
      DPC_HIGH_BW
   } dpc_mode_e;

   typedef enum logic [1:0] {
      DPC_PIN_MANUAL,
      DPC_AUTO_NONREV,
      DPC_AUTO_REV,
      DPC_REG_MANUAL
   } dpc_policy_e;

   typedef struct packed {
      logic        out0_format_sel;
      logic        out1_format_sel;
      logic [16:0] ref_prediv;
      logic [16:0] lower_loop_fb_div;
      logic [7:0]  upper_loop_fb_int;
      logic [17:0] upper_loop_fb_frac;
      logic [10:0] output_div;
      logic [6:0]  loop_settings;
   } dpc_cfg_s;

   typedef struct packed {
      logic        sel_clk1;
      logic        auto_switch;
      logic        revertive;
      logic [4:0]  adc_div;
      logic [4:0]  edge_window_us;
      logic        crystal_doubler;
   } dpc_glob_s;

endpackage

// ===== hw/dpc_regs.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps

// Operation
// RULE1: two config sets, only active applied
// RULE2: format bit 0 LVPECL, 1 LVDS
// RULE3: 17-bit reference pre-divider per config
// RULE4: 17-bit lower loop divider per config
// RULE5: 8-bit integer, 18-bit fraction upper divider
// RULE6: 11-bit output divider per config
// RULE7: 7-bit loop settings, meaning per mode
// RULE8: mode 00 low, 01 synth, else high
// RULE9: source bit 0 pin, 1 register
// RULE10: register select only under register control
// RULE11: output enabled by bit AND pin
// RULE12: software writes zero to reserved bits
// RULE13: policy pin, nonrevertive, revertive, register
// RULE14: input select bit per policy, pin ignores
// RULE15: sampling rate crystal over 16/8/4/2
// RULE16: lock window 2, 4, 8, 16 us
// RULE17: doubler bit doubles crystal to detector
// RULE18: enable bits reset to enabled
// RULE19: byte-addressed registers, sequential block access; the port here moves one byte per strobe, with no block access
// RULE20: pin low set 0, high set 1
module dpc_regs
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic [4:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [7:0]             rdata,
   input  wire logic              cfg_pin,
   input  wire logic              oe0_pin,
   input  wire logic              oe1_pin,
   input  wire logic              clk_sel_pin,
   output dpc_pkg::dpc_cfg_s      active_cfg,
   output logic                   active_set,
   output dpc_pkg::dpc_mode_e     pll_mode,
   output dpc_pkg::dpc_glob_s     glob,
   output logic                   out0_enable,
   output logic                   out1_enable
);

   ////////////////////////////////////////////////////////////////////////
   // field extraction

   // config n bytes interleave: set 0 at even, set 1 at odd offsets
   function automatic dpc_pkg::dpc_cfg_s extract_cfg
   (
      input logic [7:0] m [0:dpc_pkg::NUM_REGS-1],
      input logic       n
   );
      logic [7:0] b [0:9];
      dpc_pkg::dpc_cfg_s c;
      for (int k = 0; k < 10; k++)
      begin
         b[k] = m[2 * k + int'(n)];
      end
      // RULE5: upper divider fields
      c.upper_loop_fb_frac = {b[0], b[1], b[2][7:6]};
      c.upper_loop_fb_int = {b[2][5:0], b[3][7:6]};
      // RULE3: reference pre-divider
      c.ref_prediv = {b[3][5:0], b[4], b[5][7:5]};
      // RULE4: lower loop divider
      c.lower_loop_fb_div = {b[5][4:0], b[6], b[7][7:4]};
      // RULE6: output divider
      c.output_div = {b[7][3:0], b[8][7:1]};
      // RULE7: loop settings
      c.loop_settings = {b[8][0], b[9][7:2]};
      // RULE2: format selects
      c.out1_format_sel = b[9][1];
      c.out0_format_sel = b[9][0];
      return c;
   endfunction

   function automatic logic [7:0] write_mask
   (
      input logic [4:0] a
   );
      logic [7:0] mk;
      mk = dpc_pkg::MASK_CFG;
      if (a == dpc_pkg::ADDR_MODE)
      begin
         mk = dpc_pkg::MASK_MODE;
      end
      else if (a == dpc_pkg::ADDR_CLK)
      begin
         mk = dpc_pkg::MASK_CLK;
      end
      else if (a == dpc_pkg::ADDR_XTAL)
      begin
         mk = dpc_pkg::MASK_XTAL;
      end
      else if (a >= dpc_pkg::ADDR_STATUS)
      begin
         mk = 8'h00;
      end
      return mk;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register storage and read port

   logic [7:0] mem      [0:dpc_pkg::NUM_REGS-1];
   logic [7:0] next_mem [0:dpc_pkg::NUM_REGS-1];
   logic [7:0] next_rdata;

   always_comb
   begin
      for (int i = 0; i < dpc_pkg::NUM_REGS; i++)
      begin
         next_mem[i] = mem[i];
      end
      // RULE19: byte address selects one register
      if (wr && addr < 5'(dpc_pkg::NUM_REGS))
      begin
         // RULE12: reserved positions never stored
         next_mem[addr] = wdata & write_mask(addr);
      end
      next_rdata = 8'h00;
      if (rd && addr < 5'(dpc_pkg::NUM_REGS))
      begin
         next_rdata = mem[addr];
         if (addr == dpc_pkg::ADDR_XTAL)
         begin
            next_rdata = mem[addr] | dpc_pkg::XTAL_FIXED;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < dpc_pkg::NUM_REGS; i++)
         begin
            mem[i] <= dpc_pkg::RST_BYTE;
         end
         // RULE18: enables come up set
         mem[dpc_pkg::ADDR_MODE] <= dpc_pkg::RST_MODE;
         rdata <= 8'h00;
      end
      else
      begin
         for (int i = 0; i < dpc_pkg::NUM_REGS; i++)
         begin
            mem[i] <= next_mem[i];
         end
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: change counts once stages two and three agree

   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   logic [3:0] pins;
   logic [3:0] next_pins;

   always_comb
   begin
      next_pins = pins;
      for (int i = 0; i < 4; i++)
      begin
         if (pin_s2[i] == pin_s3[i])
         begin
            next_pins[i] = pin_s3[i];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pin_s1 <= dpc_pkg::RST_PINS;
         pin_s2 <= dpc_pkg::RST_PINS;
         pin_s3 <= dpc_pkg::RST_PINS;
         pins <= dpc_pkg::RST_PINS;
      end
      else
      begin
         pin_s1 <= {clk_sel_pin, cfg_pin, oe1_pin, oe0_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pins <= next_pins;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // applied settings

   dpc_pkg::dpc_cfg_s  next_active_cfg;
   logic               next_active_set;
   dpc_pkg::dpc_mode_e next_pll_mode;
   dpc_pkg::dpc_glob_s next_glob;
   logic               next_out0_enable;
   logic               next_out1_enable;
   logic [7:0]         mode_reg;
   logic [7:0]         clk_reg;
   logic [1:0]         mode_code;
   dpc_pkg::dpc_policy_e policy;

   always_comb
   begin
      mode_reg = mem[dpc_pkg::ADDR_MODE];
      clk_reg = mem[dpc_pkg::ADDR_CLK];
      mode_code = mode_reg[dpc_pkg::POS_MODE +: 2];
      policy = dpc_pkg::dpc_policy_e'(clk_reg[dpc_pkg::POS_POLICY +: 2]);
      // RULE9: profile source
      if (mode_reg[dpc_pkg::POS_SRC])
      begin
         // RULE10: register select applies
         next_active_set = mode_reg[dpc_pkg::POS_CONFIG];
      end
      else
      begin
         // RULE20: pin picks the set
         next_active_set = pins[dpc_pkg::PIN_CFG];
      end
      // RULE1: only the chosen set leaves
      next_active_cfg = extract_cfg(mem, next_active_set);
      // RULE8: mode decode, 10 and 11 alike
      unique case (mode_code)
         2'b00: next_pll_mode = dpc_pkg::DPC_LOW_BW;
         2'b01: next_pll_mode = dpc_pkg::DPC_SYNTH;
         default: next_pll_mode = dpc_pkg::DPC_HIGH_BW;
      endcase
      // RULE13: clock policy
      next_glob.auto_switch = (policy == dpc_pkg::DPC_AUTO_NONREV) ||
                              (policy == dpc_pkg::DPC_AUTO_REV);
      next_glob.revertive = (policy == dpc_pkg::DPC_AUTO_REV);
      // RULE14: select bit ignored under pin policy
      if (policy == dpc_pkg::DPC_PIN_MANUAL)
      begin
         next_glob.sel_clk1 = pins[dpc_pkg::PIN_CLK];
      end
      else
      begin
         next_glob.sel_clk1 = clk_reg[dpc_pkg::POS_CLKSEL];
      end
      // RULE15: converter divisor 16 down to 2
      next_glob.adc_div = dpc_pkg::RATE_BASE_DIV >>
                          clk_reg[dpc_pkg::POS_RATE +: 2];
      // RULE16: window 2 up to 16 us
      next_glob.edge_window_us = dpc_pkg::WIN_BASE_US <<
                                 clk_reg[dpc_pkg::POS_WIN +: 2];
      // RULE17: crystal doubler
      next_glob.crystal_doubler =
         mem[dpc_pkg::ADDR_XTAL][dpc_pkg::POS_DBL];
      // RULE11: bit and pin both needed
      next_out0_enable = mode_reg[dpc_pkg::POS_OE0] &
                         pins[dpc_pkg::PIN_OE0];
      next_out1_enable = mode_reg[dpc_pkg::POS_OE1] &
                         pins[dpc_pkg::PIN_OE1];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         active_cfg <= '0;
         active_set <= 1'b0;
         pll_mode <= dpc_pkg::DPC_LOW_BW;
         glob <= '0;
         out0_enable <= 1'b0;
         out1_enable <= 1'b0;
      end
      else
      begin
         active_cfg <= next_active_cfg;
         active_set <= next_active_set;
         pll_mode <= next_pll_mode;
         glob <= next_glob;
         out0_enable <= next_out0_enable;
         out1_enable <= next_out1_enable;
      end
   end

endmodule

// ===== tb/dpc_host_model.sv
`timescale 1ns/1ps
// register-port master; changes signals only right after a rising edge
module dpc_host_model
(
   input  logic       clk,
   output logic [4:0] addr,
   output logic [7:0] wdata,
   output logic       wr,
   output logic       rd,
   input  logic [7:0] rdata
);
   initial
   begin
      addr = 5'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= 8'h00;
   endtask
   task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // data stands only in the cycle after the strobe
      #1 d = rdata;
   endtask
endmodule

// ===== tb/dpc_regs_assertions.sv
`timescale 1ns/1ps
module dpc_regs_chk
(
   input logic               clk,
   input logic               srst,
   input logic [4:0]         addr,
   input logic [7:0]         wdata,
   input logic               wr,
   input logic               rd,
   input logic [7:0]         rdata,
   input logic               oe0_pin,
   input logic               oe1_pin,
   input dpc_pkg::dpc_mode_e pll_mode,
   input dpc_pkg::dpc_glob_s glob,
   input logic               active_set,
   input logic               out0_enable,
   input logic               out1_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data seen without a read");
   a_unmapped_rd: assert property (
      rd && addr >= 5'h18 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_fixed_rd: assert property (
      rd && addr == 5'h16 |=> (rdata & 8'hF7) == 8'hA0)
      else $error("crystal register pattern wrong");
   a_rsvd_rd: assert property (rd && addr == 5'h14 |=> rdata[1:0] == 2'b00)
      else $error("reserved bits read nonzero");
   a_pin_gate: assert property (!oe0_pin [*8] |-> !out0_enable)
      else $error("output 0 on with pin low");
   a_bit_gate: assert property (
      wr && addr == 5'h14 && !wdata[3] |-> ##[1:3] !out1_enable)
      else $error("output 1 on with bit low");
   a_mode_high: assert property (
      wr && addr == 5'h14 && wdata[7]
      |-> ##[1:3] pll_mode == dpc_pkg::DPC_HIGH_BW)
      else $error("mode code not high bandwidth");
   a_reg_select: assert property (
      wr && addr == 5'h14 && wdata[5:4] == 2'b11 |-> ##[1:3] active_set)
      else $error("register select ignored");
   a_doubler_on: assert property (
      wr && addr == 5'h16 && wdata[3] |-> ##[1:3] glob.crystal_doubler)
      else $error("doubler not applied");
endmodule
bind dpc_regs dpc_regs_chk u_dpc_regs_chk (.clk, .srst, .addr, .wdata, .wr,
   .rd, .rdata, .oe0_pin, .oe1_pin, .pll_mode, .glob, .active_set,
   .out0_enable, .out1_enable);

// ===== tb/dpc_regs_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module dpc_regs_tb;
   logic clk = 1'b0, srst = 1'b1, cfg_pin = 1'b0, oe0_pin = 1'b1;
   logic oe1_pin = 1'b1, clk_sel_pin = 1'b0, wr, rd, active_set;
   logic out0_enable, out1_enable;
   logic [4:0] addr;
   logic [7:0] wdata, rdata, d;
   dpc_pkg::dpc_cfg_s  active_cfg;
   dpc_pkg::dpc_mode_e pll_mode;
   dpc_pkg::dpc_mode_e exp_mode;
   dpc_pkg::dpc_glob_s glob;
   int fails = 0, samples_checked = 0, cyc = 0;
   // address, written byte, expected readback
   logic [23:0] rows [7] = '{24'h14_FFFC, 24'h15_FFEF, 24'h16_FFA8,
      24'h17_FF00, 24'h19_FF00, 24'h13_5A5A, 24'h01_C3C3};
   always #12.5 clk = ~clk;
   dpc_regs u_dpc_regs (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
      .cfg_pin, .oe0_pin, .oe1_pin, .clk_sel_pin, .active_cfg,
      .active_set, .pll_mode, .glob, .out0_enable, .out1_enable);
   dpc_host_model u_dpc_host_model (.clk, .addr, .wdata, .wr, .rd, .rdata);
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // pins need three sync stages, the pins register and the output register
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
      u_dpc_host_model.write_reg(a, v);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      settle(8);
      u_dpc_host_model.read_reg(5'h14, d);
      `CHK("reset mode reg", 8'h0C, d)
      `CHK("reset out0", 1'b1, out0_enable)
      `CHK("reset out1", 1'b1, out1_enable)
      `CHK("reset mode", dpc_pkg::DPC_LOW_BW, pll_mode)
      $display("reset test done");
      foreach (rows[i])
      begin
         wr_reg(rows[i][20:16], rows[i][15:8]);
         u_dpc_host_model.read_reg(rows[i][20:16], d);
         `CHK("readback", rows[i][7:0], d)
      end
      settle(3);
      `CHK("doubler", 1'b1, glob.crystal_doubler)
      $display("table test done");
      wr_reg(5'h14, 8'h0C);
      wr_reg(5'h00, 8'hA5);
      wr_reg(5'h02, 8'h3C);
      wr_reg(5'h04, 8'hC7);
      wr_reg(5'h06, 8'h80);
      wr_reg(5'h05, 8'h01);
      wr_reg(5'h07, 8'h00);
      wr_reg(5'h08, 8'h12);
      wr_reg(5'h0A, 8'hA9);
      wr_reg(5'h0C, 8'h34);
      wr_reg(5'h0E, 8'h56);
      wr_reg(5'h10, 8'h78);
      wr_reg(5'h12, 8'h9B);
      settle(3);
      `CHK("prediv", 17'h0_0095, active_cfg.ref_prediv)
      `CHK("lower div", 17'h0_9345, active_cfg.lower_loop_fb_div)
      `CHK("out div", 11'h33C, active_cfg.output_div)
      `CHK("loop set", 7'h26, active_cfg.loop_settings)
      `CHK("fmt0", 1'b1, active_cfg.out0_format_sel)
      `CHK("fmt1", 1'b1, active_cfg.out1_format_sel)
      `CHK("frac set0", 18'h2_94F3, active_cfg.upper_loop_fb_frac)
      `CHK("int set0", 8'h1E, active_cfg.upper_loop_fb_int)
      `CHK("pin low set", 1'b0, active_set)
      @(posedge clk) cfg_pin <= 1'b1;
      settle(8);
      `CHK("int set1", 8'h04, active_cfg.upper_loop_fb_int)
      `CHK("pin high set", 1'b1, active_set)
      wr_reg(5'h14, 8'h1C);
      settle(3);
      `CHK("reg set0", 1'b0, active_set)
      wr_reg(5'h14, 8'h3C);
      settle(3);
      `CHK("reg set1", 1'b1, active_set)
      $display("profile test done");
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(5'h14, {i[1:0], 6'h1C});
         wr_reg(5'h15, {1'b1, i[1:0], 1'b0, i[1:0], i[1:0]});
         settle(3);
         exp_mode = (i == 0) ? dpc_pkg::DPC_LOW_BW :
                    (i == 1) ? dpc_pkg::DPC_SYNTH : dpc_pkg::DPC_HIGH_BW;
         `CHK("mode", exp_mode, pll_mode)
         `CHK("rate", 5'h10 >> i, glob.adc_div)
         `CHK("window", 5'h02 << i, glob.edge_window_us)
         `CHK("auto", i == 1 || i == 2, glob.auto_switch)
         `CHK("revert", i == 2, glob.revertive)
         `CHK("clk sel", i != 0, glob.sel_clk1)
      end
      $display("mode test done");
      @(posedge clk) oe0_pin <= 1'b0;
      settle(8);
      `CHK("pin off", 1'b0, out0_enable)
      wr_reg(5'h14, 8'h14);
      settle(3);
      `CHK("bit off", 1'b0, out1_enable)
      $display("enable test done");
      print_verdict();
   end
endmodule
